//--- logic/ddid_params.svh
`ifndef DDID_PARAMS_SVH
`define DDID_PARAMS_SVH
`define DDID_NUM_DED      6
`define DDID_NUM_ALL      8
`define DDID_CLK_HZ       50000000
`define DDID_TICK_US      1000
`define DDID_TICK_CYC     ((`DDID_CLK_HZ / 1000000) * `DDID_TICK_US)
`define DDID_TICK_W       16
`define DDID_DEB_W        8
`define DDID_FUNC_W       7
`define DDID_FUNC_RST     7'h00
`define DDID_POL_RST      1'b0
`define DDID_DEB_RST      8'h03
`define DDID_F_OFF        7'h00
`define DDID_F_RUN        7'h01
`define DDID_F_RUN_REV    7'h02
`define DDID_F_COAST      7'h03
`define DDID_F_QUICK      7'h04
`define DDID_F_FAULT_ACK  7'h09
`define DDID_F_JOG_R      7'h0a
`define DDID_F_JOG_L      7'h0b
`define DDID_F_REVERSE    7'h0c
`define DDID_F_MOP_UP     7'h0d
`define DDID_F_MOP_DN     7'h0e
`define DDID_F_FIX_DIR    7'h0f
`define DDID_F_FIX_DIR_ON 7'h10
`define DDID_F_FIX_BIN_ON 7'h11
`define DDID_F_DC_BRAKE   7'h19
`define DDID_F_EXT_TRIP   7'h1d
`define DDID_F_NO_ADD_SP  7'h21
`define DDID_F_FREE_IC    7'h63
`endif

//--- logic/ddid_pkg.sv
`include "ddid_params.svh"
package ddid_pkg;
  typedef struct packed {
    logic run;
    logic run_rev;
    logic ramp_stop_n;
    logic coast_stop_n;
    logic quick_stop_n;
    logic fault_ack;
    logic jog_right;
    logic jog_left;
    logic reverse;
    logic mop_up;
    logic mop_down;
    logic fix_direct;
    logic fix_direct_run;
    logic fix_binary_run;
    logic dc_brake;
    logic ext_trip_n;
    logic add_sp_disable;
  } ddid_cmd_t;

  typedef struct packed {
    logic [`DDID_TICK_W-1:0]                    tick_cnt;
    logic [`DDID_NUM_ALL-1:0]                   filt;
    logic [`DDID_NUM_ALL-1:0][`DDID_DEB_W-1:0]  deb_cnt;
    logic [`DDID_NUM_ALL-1:0]                   status;
    ddid_cmd_t                                  cmd;
    logic [`DDID_NUM_ALL-1:0]                   free_ic;
    logic [`DDID_NUM_ALL-1:0]                   free_bits;
    logic [`DDID_NUM_ALL-1:0][3:0]              fix_sel;
  } ddid_state_t;
endpackage : ddid_pkg

//--- logic/ddid_decoder.sv
`timescale 1ns/1ps
// Functional notes
// - six dedicated inputs plus two analog inputs usable as digital give eight.
// - a polarity select makes inputs active high or active low before decode.
// - each input is debounced with a configurable time against switch noise.
// - codes 0,1,2,3,4,9 are off, run, run reversed, coast, quick stop, fault ack.
// - codes 10,11 jog right/left, 12 reverse, 13/14 motor pot up/down.
// - codes 15,16,17 are fixed setpoint direct, direct with run, binary with run.
// - code 25 enables dc braking, 29 is external trip, 33 drops added setpoint.
// - code 99 hands the input to free signal interconnection.
// - a status word shows one bit per input, all eight, after conditioning.
`include "ddid_params.svh"
module ddid_decoder (
  input  wire logic                                   clk_i,
  input  wire logic                                   arst_n_i,
  input  wire logic [`DDID_NUM_DED-1:0]               din_i,
  input  wire logic [1:0]                             ain_digital_i,
  input  wire logic [1:0]                             ain_as_din_en_i,
  input  wire logic                                   input_polarity_select_i,
  input  wire logic [`DDID_DEB_W-1:0]                 input_debounce_time_i,
  input  wire logic                                   func_wr_i,
  input  wire logic [2:0]                             func_wr_idx_i,
  input  wire logic [`DDID_FUNC_W-1:0]                func_wr_data_i,
  output logic [`DDID_NUM_ALL-1:0]                    input_status_word_o,
  output ddid_pkg::ddid_cmd_t                         cmd_o,
  output logic [`DDID_NUM_ALL-1:0]                    free_ic_en_o,
  output logic [`DDID_NUM_ALL-1:0]                    free_ic_bits_o,
  output logic [3:0]                                  fix_sel_o
);

  //////////////////////////////////////////////////////////////////////////////
  // function code table, kept in flops from reset
  logic [`DDID_NUM_ALL-1:0][`DDID_FUNC_W-1:0] func_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < `DDID_NUM_ALL; i++) begin
        func_reg[i] <= `DDID_FUNC_RST;
      end
    end else if (func_wr_i) begin
      func_reg[func_wr_idx_i] <= func_wr_data_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // raw input assembly and polarity
  logic [`DDID_NUM_ALL-1:0] raw_in;
  always_comb begin
    raw_in = {ain_digital_i & ain_as_din_en_i, din_i};
    if (input_polarity_select_i) begin
      raw_in = ~raw_in;
    end
    raw_in[`DDID_NUM_ALL-1:`DDID_NUM_DED] =
      raw_in[`DDID_NUM_ALL-1:`DDID_NUM_DED] & ain_as_din_en_i;
  end

  function automatic logic is_code(input logic [`DDID_FUNC_W-1:0] f,
                                   input logic [`DDID_FUNC_W-1:0] c);
    is_code = (f == c);
  endfunction : is_code

  //////////////////////////////////////////////////////////////////////////////
  // state
  ddid_pkg::ddid_state_t st_reg;
  ddid_pkg::ddid_state_t st_next;

  always_comb begin
    logic tick;
    logic [3:0] fsel;
    ddid_pkg::ddid_cmd_t c;
    tick = 1'b0;
    fsel = 4'h0;
    c = '0;
    st_next = st_reg;
    if (st_reg.tick_cnt == `DDID_TICK_W'(`DDID_TICK_CYC - 1)) begin
      st_next.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + `DDID_TICK_W'(1);
    end
    for (int i = 0; i < `DDID_NUM_ALL; i++) begin
      if (raw_in[i] == st_reg.filt[i]) begin
        st_next.deb_cnt[i] = '0;
      end else if (tick) begin
        if (st_reg.deb_cnt[i] >= input_debounce_time_i) begin
          st_next.filt[i] = raw_in[i];
          st_next.deb_cnt[i] = '0;
        end else begin
          st_next.deb_cnt[i] = st_reg.deb_cnt[i] + `DDID_DEB_W'(1);
        end
      end
    end
    st_next.status = st_reg.filt;
    c.ramp_stop_n = 1'b1;
    c.coast_stop_n = 1'b1;
    c.quick_stop_n = 1'b1;
    c.ext_trip_n = 1'b1;
    for (int i = 0; i < `DDID_NUM_ALL; i++) begin
      logic a;
      logic [`DDID_FUNC_W-1:0] f;
      a = st_reg.filt[i];
      f = func_reg[i];
      st_next.free_ic[i] = is_code(f, `DDID_F_FREE_IC);
      st_next.free_bits[i] = a & is_code(f, `DDID_F_FREE_IC);
      unique case (f)
        `DDID_F_OFF: begin
        end
        `DDID_F_RUN: begin
          if (a) begin
            c.run = 1'b1;
          end else begin
            c.ramp_stop_n = 1'b0;
          end
        end
        `DDID_F_RUN_REV: begin
          if (a) begin
            c.run_rev = 1'b1;
          end else begin
            c.ramp_stop_n = 1'b0;
          end
        end
        `DDID_F_COAST: begin
          if (!a) begin
            c.coast_stop_n = 1'b0;
          end
        end
        `DDID_F_QUICK: begin
          if (!a) begin
            c.quick_stop_n = 1'b0;
          end
        end
        `DDID_F_FAULT_ACK: begin
          if (a) begin
            c.fault_ack = 1'b1;
          end
        end
        `DDID_F_JOG_R: begin
          if (a) begin
            c.jog_right = 1'b1;
          end
        end
        `DDID_F_JOG_L: begin
          if (a) begin
            c.jog_left = 1'b1;
          end
        end
        `DDID_F_REVERSE: begin
          if (a) begin
            c.reverse = 1'b1;
          end
        end
        `DDID_F_MOP_UP: begin
          if (a) begin
            c.mop_up = 1'b1;
          end
        end
        `DDID_F_MOP_DN: begin
          if (a) begin
            c.mop_down = 1'b1;
          end
        end
        `DDID_F_FIX_DIR: begin
          if (a) begin
            c.fix_direct = 1'b1;
            fsel = fsel | 4'(i + 1);
          end
        end
        `DDID_F_FIX_DIR_ON: begin
          if (a) begin
            c.fix_direct_run = 1'b1;
            fsel = fsel | 4'(i + 1);
          end
        end
        `DDID_F_FIX_BIN_ON: begin
          if (a) begin
            c.fix_binary_run = 1'b1;
            fsel = fsel | 4'(i + 1);
          end
        end
        `DDID_F_DC_BRAKE: begin
          if (a) begin
            c.dc_brake = 1'b1;
          end
        end
        `DDID_F_EXT_TRIP: begin
          if (!a) begin
            c.ext_trip_n = 1'b0;
          end
        end
        `DDID_F_NO_ADD_SP: begin
          if (a) begin
            c.add_sp_disable = 1'b1;
          end
        end
        default: begin
          // unknown codes and free interconnection drive no command
        end
      endcase
      st_next.fix_sel[i] = '0;
    end
    st_next.fix_sel[0] = fsel;
    st_next.cmd = c;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
      st_reg.cmd.ramp_stop_n <= 1'b1;
      st_reg.cmd.coast_stop_n <= 1'b1;
      st_reg.cmd.quick_stop_n <= 1'b1;
      st_reg.cmd.ext_trip_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign input_status_word_o = st_reg.status;
  assign cmd_o               = st_reg.cmd;
  assign free_ic_en_o        = st_reg.free_ic;
  assign free_ic_bits_o      = st_reg.free_bits;
  assign fix_sel_o           = st_reg.fix_sel[0];

endmodule : ddid_decoder

//--- tb/ddid_decoder_chk.sv
`timescale 1ns/1ps
module ddid_decoder_chk (
  input wire logic                clk_i,
  input wire logic                arst_n_i,
  input wire logic                func_wr_i,
  input wire logic [2:0]          func_wr_idx_i,
  input wire logic [6:0]          func_wr_data_i,
  input wire logic [7:0]          input_status_word_o,
  input wire ddid_pkg::ddid_cmd_t cmd_o,
  input wire logic [7:0]          free_ic_en_o,
  input wire logic [7:0]          free_ic_bits_o,
  input wire logic [3:0]          fix_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_STAT_HOLD: assert property (
    $changed(input_status_word_o) |=> $stable(input_status_word_o)[*8])
    else $error("status changed too soon");
  AST_RST_OFF: assert property (
    $rose(arst_n_i) |-> cmd_o == 17'h07002 && free_ic_en_o == 8'h00)
    else $error("reset outputs wrong");
  AST_FREE_SET: assert property (
    func_wr_i && func_wr_data_i == 7'h63 ##1 !func_wr_i
    |=> free_ic_en_o[$past(func_wr_idx_i, 2)]) else $error("free not set");
  AST_FREE_CLR: assert property (
    func_wr_i && func_wr_data_i != 7'h63 ##1 !func_wr_i
    |=> !free_ic_en_o[$past(func_wr_idx_i, 2)]) else $error("free not clear");
  AST_FREE_SUB: assert property (
    (free_ic_bits_o & ~free_ic_en_o) == 8'h00) else $error("free bit leak");
  AST_FIX_SEL: assert property (
    fix_sel_o != 4'h0 |-> cmd_o.fix_direct || cmd_o.fix_direct_run
    || cmd_o.fix_binary_run) else $error("fixed select without command");
  AST_RUN_ON: assert property (
    func_wr_i && func_wr_data_i == 7'h01 && input_status_word_o[func_wr_idx_i]
    ##1 !func_wr_i |=> cmd_o.run) else $error("run not decoded");
  AST_TRIP_ON: assert property (
    func_wr_i && func_wr_data_i == 7'h1d && !input_status_word_o[func_wr_idx_i]
    ##1 !func_wr_i |=> !cmd_o.ext_trip_n) else $error("trip not decoded");
endmodule : ddid_decoder_chk
bind ddid_decoder ddid_decoder_chk u_chk (.clk_i, .arst_n_i, .func_wr_i,
  .func_wr_idx_i, .func_wr_data_i, .input_status_word_o, .cmd_o,
  .free_ic_en_o, .free_ic_bits_o, .fix_sel_o);

//--- tb/ddid_sw_model.sv
`timescale 1ns/1ps
module ddid_sw_model (
  input  wire logic [7:0] act_i,
  input  wire logic       pol_i,
  input  wire logic       clk_i,
  output logic [5:0]      din_o = 6'h00,
  output logic [1:0]      ain_o = 2'h0
);
  logic [2:0] bounce_reg = 3'h0;
  logic [7:0] last_reg = 8'h00;
  // contacts chatter a few cycles after each change
  always @(negedge clk_i) begin
    if (act_i != last_reg) bounce_reg <= 3'h7;
    else if (bounce_reg != 3'h0) bounce_reg <= bounce_reg - 3'h1;
    last_reg <= act_i;
    {ain_o, din_o} <= act_i ^ {8{pol_i}} ^ {8{bounce_reg[0]}};
  end
endmodule : ddid_sw_model

//--- tb/ddid_decoder_tb_top.sv
`timescale 1ns/1ps
module ddid_decoder_tb_top;
  logic                clk_i = 1'b0;
  logic                arst_n_i = 1'b0;
  logic                wr = 1'b0;
  logic                pol = 1'b0;
  logic [6:0]          code = 7'h00;
  logic [7:0]          act = 8'h00;
  logic [7:0]          prev = 8'h00;
  logic [2:0]          dly = 3'h0;
  logic [31:0]         seed = 32'd77406;
  logic [5:0]          din;
  logic [1:0]          ain;
  logic [7:0]          stat, fen, fbits;
  logic [3:0]          fsel;
  ddid_pkg::ddid_cmd_t cmd;
  logic [36:0]         q_cmd [$];
  logic [36:0]         q_st [$];
  int                  fails = 0;
  int                  check_count = 0;
  int                  cyc = 0;
  ////////////////////////////////////////
  initial forever #10 clk_i = ~clk_i;
  ddid_sw_model sw (.clk_i, .act_i(act), .pol_i(pol), .din_o(din), .ain_o(ain));
  ddid_decoder uut (.clk_i, .arst_n_i, .din_i(din), .ain_digital_i(ain),
    .ain_as_din_en_i(2'h3), .input_polarity_select_i(pol),
    .input_debounce_time_i(8'h00), .func_wr_i(wr), .func_wr_idx_i(3'h0),
    .func_wr_data_i(code), .input_status_word_o(stat), .cmd_o(cmd),
    .free_ic_en_o(fen), .free_ic_bits_o(fbits), .fix_sel_o(fsel));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [36:0] exp_out(input logic [6:0] c, input logic a);
    logic [16:0] s;
    logic [16:0] k;
    s = 17'h0;
    k = 17'h0;
    if (c == 7'h01 || c == 7'h02) s[7'd17 - c] = 1'b1;
    if (c == 7'h01 || c == 7'h02) k[14] = 1'b1;
    if (c == 7'h03 || c == 7'h04) k[7'd16 - c] = 1'b1;
    if (c >= 7'h09 && c <= 7'h11) s[7'd20 - c] = 1'b1;
    if (c == 7'h19) s[2] = 1'b1;
    if (c == 7'h1d) k[1] = 1'b1;
    if (c == 7'h21) s[0] = 1'b1;
    return {a ? 17'h07002 | s : 17'h07002 & ~k, 7'h00, c == 7'h63, 7'h00,
      a && c == 7'h63, 3'h0, a && c >= 7'h0f && c <= 7'h11};
  endfunction : exp_out
  task automatic cmp(input logic [36:0] e, input logic [36:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_st(input logic [36:0] e, input logic [7:0] g);
    cmp(e, {29'h0, g});
  endtask : cmp_st
  task automatic conclude();
    fails += q_st.size() + q_cmd.size();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic phase(input logic [7:0] v);
    act = v;
    q_st.push_back({29'h0, v});
    for (int i = 0; i < 52000 && stat !== v; i++) @(negedge clk_i);
    @(negedge clk_i);
  endtask : phase
  task automatic sweep(input logic a);
    logic [6:0] t [20] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h09,
      7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h19, 7'h1d,
      7'h21, 7'h63, 7'h00};
    for (int i = 0; i < 20; i++) begin
      q_cmd.push_back(exp_out(t[i], a));
      wr = 1'b1;
      code = t[i];
      @(negedge clk_i);
      wr = 1'b0;
      repeat (2) @(negedge clk_i);
    end
  endtask : sweep
  always @(posedge clk_i) begin
    dly <= {dly[1:0], wr};
    cyc++;
    if (cyc == 102000) begin
      fails++;
      conclude();
    end
  end
  always @(negedge clk_i) begin
    if (arst_n_i && stat !== prev) cmp_st(q_st.pop_front(), stat);
    prev = stat;
    if (dly[2]) cmp(q_cmd.pop_front(), {cmd, fen, fbits, fsel});
  end
  initial begin
    repeat (6) @(negedge clk_i);
    arst_n_i = 1'b1;
    phase(8'(rnd()) | 8'h01);
    sweep(1'b1);
    pol = 1'b1;
    phase(8'(rnd()) & 8'hfe);
    sweep(1'b0);
    @(negedge clk_i);
    conclude();
  end
endmodule : ddid_decoder_tb_top
